// ==== logic/rac_regs.svh ====
// Offsets, field positions and reset values of the radio analog control bank
// Functional notes
// RQ1: Upper power nibble drives high array, reset 0
// RQ2: Lower power nibble drives low array, reset 15
// RQ3: Host should use only one power nibble
// RQ4: Upper match nibble selects receive capacitor array
// RQ5: Lower match nibble selects transmit capacitor array
// RQ6: Signed phase trim byte, reset zero
// RQ7: Signed gain trim byte, reset zero
// RQ8: Sleep bits act only when policy equals two
// RQ9: Sleep bit order amp down to converter
// RQ10: Open-loop DAC value applies only while loop open
// RQ11: Loop-open bit opens synthesizer loop, reset clear
// RQ12: Pump force selects pump override value, reset 13
// RQ13: Array force selects oscillator array override, reset 16
// RQ14: Current force selects oscillator current override, reset 6
// RQ15: Manual calibration samples comparator on strobe falling edge
// RQ16: All registers reset to defaults and hold writes
`ifndef RAC_REGS_SVH
`define RAC_REGS_SVH

`define RAC_OFF_PWR      7'h1C
`define RAC_OFF_MATCH    7'h1D
`define RAC_OFF_PHASE    7'h1E
`define RAC_OFF_GAIN     7'h1F
`define RAC_OFF_SLEEP    7'h20
`define RAC_OFF_TST1     7'h21
`define RAC_OFF_TST2     7'h22
`define RAC_OFF_TST3     7'h23

`define RAC_IX_PWR       3'h0
`define RAC_IX_MATCH     3'h1
`define RAC_IX_PHASE     3'h2
`define RAC_IX_GAIN      3'h3
`define RAC_IX_SLEEP     3'h4
`define RAC_IX_TST1      3'h5
`define RAC_IX_TST2      3'h6
`define RAC_IX_TST3      3'h7

`define RAC_RST_PWR      8'h0F
`define RAC_RST_MATCH    8'h00
`define RAC_RST_PHASE    8'h00
`define RAC_RST_GAIN     8'h00
`define RAC_RST_SLEEP    8'h00
`define RAC_RST_TST1     8'h4D
`define RAC_RST_TST2     8'h10
`define RAC_RST_TST3     8'h06

`define RAC_NIB_HI       7:4
`define RAC_NIB_LO       3:0
`define RAC_ARRAY_FIELD  4:0
`define RAC_CUR_FIELD    5:0
`define RAC_LOOP_OPEN    7
`define RAC_PUMP_FORCE   6
`define RAC_ARRAY_FORCE  5
`define RAC_BY_HAND      7
`define RAC_CUR_FORCE    6
`define RAC_POLICY_SLEEP 2'h2

`endif

// ==== logic/rac_pkg.sv ====
// Types shared by the radio analog control bank
`default_nettype none
package rac_pkg;

    typedef enum logic [1:0] {
        RAC_SER_IDLE = 2'b00,
        RAC_SER_ADDR = 2'b01,
        RAC_SER_DATA = 2'b10,
        RAC_SER_DONE = 2'b11
    } rac_ser_state_t;

    typedef struct packed {
        logic       we;
        logic [6:0] addr;
        logic [7:0] data;
    } rac_wr_t;

    typedef struct packed {
        logic [3:0] high_array_power;
        logic [3:0] low_array_power;
        logic [3:0] rx_match;
        logic [3:0] tx_match;
        logic [7:0] phase_trim;
        logic [7:0] gain_trim;
        logic [7:0] sleep;
        logic       loop_open;
        logic [3:0] cal_dac;
        logic [3:0] pump_current;
        logic [4:0] osc_array;
        logic [5:0] osc_current;
        logic       osc_cal_by_hand;
        logic       osc_cal_strobe;
        logic       osc_cal_sample;
        logic       osc_cal_result;
    } rac_analog_t;

endpackage
`default_nettype wire

// ==== logic/rac_serial_port.sv ====
// Four-wire serial configuration port: 7 address bits, R/W bit, 8 data bits
`timescale 1ns/10ps
`default_nettype none
module rac_serial_port (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic             pclk,
    input  wire logic             pdi,
    input  wire logic             psel_n,
    input  wire logic [7:0]       rd_data,
    output logic      [6:0]       rd_addr,
    output var rac_pkg::rac_wr_t  wr_q,
    output logic                  pdo_q
);
    rac_pkg::rac_ser_state_t state_q;
    logic       pclk_q;
    logic [2:0] cnt_q;
    logic [7:0] shift_q;
    logic [7:0] out_q;
    logic       is_write_q;
    logic       rise;
    logic       fall;

    assign rise    = pclk & ~pclk_q;
    assign fall    = ~pclk & pclk_q;
    assign rd_addr = shift_q[6:0];

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pclk_q <= 1'b0;
        end else begin
            pclk_q <= pclk;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst || psel_n) begin
            state_q    <= rac_pkg::RAC_SER_IDLE;
            cnt_q      <= 3'h0;
            shift_q    <= 8'h00;
            is_write_q <= 1'b0;
            out_q      <= 8'h00;
            wr_q       <= '0;
        end else begin
            wr_q.we <= 1'b0;
            case (state_q)
                rac_pkg::RAC_SER_IDLE: begin
                    state_q <= rac_pkg::RAC_SER_ADDR;
                    cnt_q   <= 3'h0;
                end
                rac_pkg::RAC_SER_ADDR: begin
                    if (rise) begin
                        shift_q <= {shift_q[6:0], pdi};
                        cnt_q   <= cnt_q + 3'h1;
                        if (cnt_q == 3'h7) begin
                            // Read data is fetched with the address still in shift_q
                            wr_q.addr  <= shift_q[6:0];
                            is_write_q <= pdi;
                            out_q      <= rd_data;
                            state_q    <= rac_pkg::RAC_SER_DATA;
                        end
                    end
                end
                rac_pkg::RAC_SER_DATA: begin
                    if (rise) begin
                        shift_q <= {shift_q[6:0], pdi};
                        cnt_q   <= cnt_q + 3'h1;
                        if (cnt_q == 3'h7) begin
                            wr_q.we   <= is_write_q;
                            wr_q.data <= {shift_q[6:0], pdi};
                            state_q   <= rac_pkg::RAC_SER_DONE;
                        end
                    end
                    if (fall && !is_write_q) begin
                        out_q <= {out_q[6:0], 1'b0};
                    end
                end
                rac_pkg::RAC_SER_DONE: begin
                    // Extra clocks are ignored until select is released
                    state_q <= rac_pkg::RAC_SER_DONE;
                end
                default: begin
                    state_q <= rac_pkg::RAC_SER_IDLE;
                end
            endcase
        end
    end

    // Read data leaves on falling edges so the host can sample on rising ones
    always_ff @(posedge core_clk) begin
        if (rst || psel_n) begin
            pdo_q <= 1'b0;
        end else if (fall && state_q == rac_pkg::RAC_SER_DATA && !is_write_q) begin
            pdo_q <= out_q[7];
        end
    end
endmodule
`default_nettype wire

// ==== logic/rac_analog_regs.sv ====
// Radio analog control register bank with override and power-down steering
`timescale 1ns/10ps
`default_nettype none
`include "rac_regs.svh"
module rac_analog_regs (
    input  wire logic                core_clk,
    input  wire logic                rst,
    input  wire logic                pclk,
    input  wire logic                pdi,
    input  wire logic                psel_n,
    output logic                     pdo_q,
    input  wire logic [1:0]          block_sleep_bits_policy,
    input  wire logic [3:0]          cal_dac_value,
    input  wire logic [3:0]          cal_pump_current,
    input  wire logic [4:0]          cal_osc_array,
    input  wire logic [5:0]          cal_osc_current,
    input  wire logic                osc_cal_compare,
    output var rac_pkg::rac_analog_t analog_ctl_q
);
    localparam int          NUM_REGS  = 8;
    localparam logic [7:0]  RST_PWR   = `RAC_RST_PWR;
    localparam logic [7:0]  RST_MATCH = `RAC_RST_MATCH;
    localparam logic [7:0]  RST_PHASE = `RAC_RST_PHASE;
    localparam logic [7:0]  RST_GAIN  = `RAC_RST_GAIN;
    localparam logic [7:0]  RST_SLEEP = `RAC_RST_SLEEP;
    localparam logic [7:0]  RST_TST3  = `RAC_RST_TST3;

    logic [7:0]       regs_q [NUM_REGS];
    rac_pkg::rac_wr_t wr_q;
    logic [6:0]       rd_addr;
    logic [7:0]       rd_data;
    logic [3:0]       wr_sel;
    logic [3:0]       rd_sel;
    logic             strobe_now;
    logic             strobe_fall;

    // Returns {hit, index}; an unmapped address gives hit low
    function automatic logic [3:0] reg_sel(input logic [6:0] addr);
        logic [3:0] sel;
        sel = 4'h0;
        if (addr == `RAC_OFF_PWR) begin
            sel = {1'b1, `RAC_IX_PWR};
        end else if (addr == `RAC_OFF_MATCH) begin
            sel = {1'b1, `RAC_IX_MATCH};
        end else if (addr == `RAC_OFF_PHASE) begin
            sel = {1'b1, `RAC_IX_PHASE};
        end else if (addr == `RAC_OFF_GAIN) begin
            sel = {1'b1, `RAC_IX_GAIN};
        end else if (addr == `RAC_OFF_SLEEP) begin
            sel = {1'b1, `RAC_IX_SLEEP};
        end else if (addr == `RAC_OFF_TST1) begin
            sel = {1'b1, `RAC_IX_TST1};
        end else if (addr == `RAC_OFF_TST2) begin
            sel = {1'b1, `RAC_IX_TST2};
        end else if (addr == `RAC_OFF_TST3) begin
            sel = {1'b1, `RAC_IX_TST3};
        end
        return sel;
    endfunction

    function automatic logic [7:0] reg_reset(input int idx);
        logic [7:0] val;
        val = 8'h00;
        case (idx)
            0:       val = `RAC_RST_PWR;
            1:       val = `RAC_RST_MATCH;
            2:       val = `RAC_RST_PHASE;
            3:       val = `RAC_RST_GAIN;
            4:       val = `RAC_RST_SLEEP;
            5:       val = `RAC_RST_TST1;
            6:       val = `RAC_RST_TST2;
            7:       val = `RAC_RST_TST3;
            default: val = 8'h00;
        endcase
        return val;
    endfunction

    rac_serial_port u_serial (
        .core_clk (core_clk),
        .rst      (rst),
        .pclk     (pclk),
        .pdi      (pdi),
        .psel_n   (psel_n),
        .rd_data  (rd_data),
        .rd_addr  (rd_addr),
        .wr_q     (wr_q),
        .pdo_q    (pdo_q)
    );

    assign wr_sel = reg_sel(wr_q.addr);
    assign rd_sel = reg_sel(rd_addr);
    // Unmapped addresses read back as zero
    assign rd_data = rd_sel[3] ? regs_q[rd_sel[2:0]] : 8'h00;

    generate
        for (genvar g = 0; g < NUM_REGS; g++) begin : g_reg
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    regs_q[g] <= reg_reset(g); // RQ16
                end else if (wr_q.we && wr_sel == {1'b1, 3'(g)}) begin
                    regs_q[g] <= wr_q.data; // RQ16
                end
            end
        end
    endgenerate

    // Front-end power, matching and trim fields
    always_ff @(posedge core_clk) begin
        if (rst) begin
            analog_ctl_q.high_array_power <= RST_PWR[`RAC_NIB_HI];
            analog_ctl_q.low_array_power  <= RST_PWR[`RAC_NIB_LO];
            analog_ctl_q.rx_match         <= RST_MATCH[`RAC_NIB_HI];
            analog_ctl_q.tx_match         <= RST_MATCH[`RAC_NIB_LO];
            analog_ctl_q.phase_trim       <= RST_PHASE;
            analog_ctl_q.gain_trim        <= RST_GAIN;
        end else begin
            analog_ctl_q.high_array_power <= regs_q[`RAC_IX_PWR][`RAC_NIB_HI]; // RQ1
            analog_ctl_q.low_array_power  <= regs_q[`RAC_IX_PWR][`RAC_NIB_LO]; // RQ2
            analog_ctl_q.rx_match         <= regs_q[`RAC_IX_MATCH][`RAC_NIB_HI]; // RQ4
            analog_ctl_q.tx_match         <= regs_q[`RAC_IX_MATCH][`RAC_NIB_LO]; // RQ5
            analog_ctl_q.phase_trim       <= regs_q[`RAC_IX_PHASE]; // RQ6
            analog_ctl_q.gain_trim        <= regs_q[`RAC_IX_GAIN]; // RQ7
        end
    end

    // Sleep bits pass only under the register-driven policy; bit 7 amp .. bit 0 converter
    always_ff @(posedge core_clk) begin
        if (rst) begin
            analog_ctl_q.sleep <= RST_SLEEP;
        end else if (block_sleep_bits_policy == `RAC_POLICY_SLEEP) begin
            analog_ctl_q.sleep <= regs_q[`RAC_IX_SLEEP]; // RQ8 RQ9
        end else begin
            analog_ctl_q.sleep <= 8'h00; // RQ8
        end
    end

    // Synthesizer loop and calibration overrides; calibrated paths read zero in reset
    always_ff @(posedge core_clk) begin
        if (rst) begin
            analog_ctl_q.loop_open    <= 1'b0;
            analog_ctl_q.cal_dac      <= 4'h0;
            analog_ctl_q.pump_current <= 4'h0;
            analog_ctl_q.osc_array    <= 5'h00;
            analog_ctl_q.osc_current  <= 6'h00;
        end else begin
            analog_ctl_q.loop_open <= regs_q[`RAC_IX_TST2][`RAC_LOOP_OPEN]; // RQ11
            if (regs_q[`RAC_IX_TST2][`RAC_LOOP_OPEN]) begin
                analog_ctl_q.cal_dac <= regs_q[`RAC_IX_TST1][`RAC_NIB_HI]; // RQ10
            end else begin
                analog_ctl_q.cal_dac <= cal_dac_value;
            end
            if (regs_q[`RAC_IX_TST2][`RAC_PUMP_FORCE]) begin
                analog_ctl_q.pump_current <= regs_q[`RAC_IX_TST1][`RAC_NIB_LO]; // RQ12
            end else begin
                analog_ctl_q.pump_current <= cal_pump_current;
            end
            if (regs_q[`RAC_IX_TST2][`RAC_ARRAY_FORCE]) begin
                analog_ctl_q.osc_array <= regs_q[`RAC_IX_TST2][`RAC_ARRAY_FIELD]; // RQ13
            end else begin
                analog_ctl_q.osc_array <= cal_osc_array;
            end
            if (regs_q[`RAC_IX_TST3][`RAC_CUR_FORCE]) begin
                analog_ctl_q.osc_current <= regs_q[`RAC_IX_TST3][`RAC_CUR_FIELD]; // RQ14
            end else begin
                analog_ctl_q.osc_current <= cal_osc_current;
            end
        end
    end

    // Manual calibration: the force bit doubles as the strobe only in manual mode
    assign strobe_now  = regs_q[`RAC_IX_TST3][`RAC_BY_HAND] & regs_q[`RAC_IX_TST3][`RAC_CUR_FORCE];
    assign strobe_fall = analog_ctl_q.osc_cal_strobe & ~strobe_now
                         & regs_q[`RAC_IX_TST3][`RAC_BY_HAND];

    always_ff @(posedge core_clk) begin
        if (rst) begin
            analog_ctl_q.osc_cal_by_hand <= RST_TST3[`RAC_BY_HAND];
            analog_ctl_q.osc_cal_strobe  <= 1'b0;
            analog_ctl_q.osc_cal_sample  <= 1'b0;
            analog_ctl_q.osc_cal_result  <= 1'b0;
        end else begin
            analog_ctl_q.osc_cal_by_hand <= regs_q[`RAC_IX_TST3][`RAC_BY_HAND];
            analog_ctl_q.osc_cal_strobe  <= strobe_now; // RQ15
            analog_ctl_q.osc_cal_sample  <= strobe_fall; // RQ15
            // Result holds between strobes so software may read it at leisure
            if (strobe_fall) begin
                analog_ctl_q.osc_cal_result <= osc_cal_compare; // RQ15
            end
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    property p_high_write;
        wr_q.we && wr_q.addr == `RAC_OFF_PWR
            |-> ##2 analog_ctl_q.high_array_power == $past(wr_q.data[7:4], 2);
    endproperty
    a_high_write: assert property (p_high_write) else $error("high array power wrong"); // RQ1

    property p_low_reset;
        $fell(rst) |-> analog_ctl_q.low_array_power == 4'hF
                       && regs_q[`RAC_IX_PWR] == RST_PWR;
    endproperty
    a_low_reset: assert property (p_low_reset) else $error("low array power reset wrong"); // RQ2

    property p_rx_match;
        ##1 analog_ctl_q.rx_match == $past(regs_q[`RAC_IX_MATCH][7:4]);
    endproperty
    a_rx_match: assert property (p_rx_match) else $error("rx match not following"); // RQ4

    property p_tx_match;
        $changed(regs_q[`RAC_IX_MATCH][3:0])
            |=> analog_ctl_q.tx_match == $past(regs_q[`RAC_IX_MATCH][3:0]);
    endproperty
    a_tx_match: assert property (p_tx_match) else $error("tx match not following"); // RQ5

    property p_phase_write;
        wr_q.we && wr_q.addr == `RAC_OFF_PHASE
            |-> ##2 analog_ctl_q.phase_trim == $past(wr_q.data, 2);
    endproperty
    a_phase_write: assert property (p_phase_write) else $error("phase trim wrong"); // RQ6

    property p_gain_hold;
        !(wr_q.we && wr_q.addr == `RAC_OFF_GAIN) [*3]
            |-> $stable(analog_ctl_q.gain_trim);
    endproperty
    a_gain_hold: assert property (p_gain_hold) else $error("gain trim moved"); // RQ7

    property p_sleep_gate;
        block_sleep_bits_policy != `RAC_POLICY_SLEEP |=> analog_ctl_q.sleep == 8'h00;
    endproperty
    a_sleep_gate: assert property (p_sleep_gate) else $error("sleep leaked"); // RQ8

    property p_sleep_pass;
        block_sleep_bits_policy == `RAC_POLICY_SLEEP
            |=> analog_ctl_q.sleep == $past(regs_q[`RAC_IX_SLEEP]);
    endproperty
    a_sleep_pass: assert property (p_sleep_pass) else $error("sleep not passed"); // RQ9

    property p_dac_closed;
        !regs_q[`RAC_IX_TST2][7] |=> analog_ctl_q.cal_dac == $past(cal_dac_value);
    endproperty
    a_dac_closed: assert property (p_dac_closed) else $error("dac override leaked"); // RQ10

    property p_loop_open;
        regs_q[`RAC_IX_TST2][7] |=> analog_ctl_q.loop_open
            && analog_ctl_q.cal_dac == $past(regs_q[`RAC_IX_TST1][7:4]);
    endproperty
    a_loop_open: assert property (p_loop_open) else $error("loop open wrong"); // RQ11

    property p_pump;
        !regs_q[`RAC_IX_TST2][6] |=> analog_ctl_q.pump_current == $past(cal_pump_current);
    endproperty
    a_pump: assert property (p_pump) else $error("pump source wrong"); // RQ12

    property p_array;
        regs_q[`RAC_IX_TST2][5]
            |=> analog_ctl_q.osc_array == $past(regs_q[`RAC_IX_TST2][4:0]);
    endproperty
    a_array: assert property (p_array) else $error("array override wrong"); // RQ13

    property p_current;
        regs_q[`RAC_IX_TST3][6]
            |=> analog_ctl_q.osc_current == $past(regs_q[`RAC_IX_TST3][5:0]);
    endproperty
    a_current: assert property (p_current) else $error("current override wrong"); // RQ14

    property p_cal_sample;
        analog_ctl_q.osc_cal_strobe && regs_q[`RAC_IX_TST3][7] && !regs_q[`RAC_IX_TST3][6]
            |=> analog_ctl_q.osc_cal_sample
                && analog_ctl_q.osc_cal_result == $past(osc_cal_compare);
    endproperty
    a_cal_sample: assert property (p_cal_sample) else $error("cal sample missed"); // RQ15

    property p_reset_defaults;
        $fell(rst) |-> regs_q[`RAC_IX_TST1] == 8'h4D && regs_q[`RAC_IX_TST2] == 8'h10
                       && regs_q[`RAC_IX_TST3] == 8'h06;
    endproperty
    a_reset_defaults: assert property (p_reset_defaults) else $error("reset defaults wrong"); // RQ16

    property p_pump_force;
        regs_q[`RAC_IX_TST2][6]
            |=> analog_ctl_q.pump_current == $past(regs_q[`RAC_IX_TST1][3:0]);
    endproperty
    a_pump_force: assert property (p_pump_force) else $error("pump override wrong"); // RQ12

    property p_array_cal;
        !regs_q[`RAC_IX_TST2][5] |=> analog_ctl_q.osc_array == $past(cal_osc_array);
    endproperty
    a_array_cal: assert property (p_array_cal) else $error("cal array lost"); // RQ13

    property p_current_cal;
        !regs_q[`RAC_IX_TST3][6] |=> analog_ctl_q.osc_current == $past(cal_osc_current);
    endproperty
    a_current_cal: assert property (p_current_cal) else $error("cal current lost"); // RQ14

    // A stuck sample pulse would take the comparator again on every cycle
    property p_cal_pulse;
        analog_ctl_q.osc_cal_sample |=> !analog_ctl_q.osc_cal_sample;
    endproperty
    a_cal_pulse: assert property (p_cal_pulse) else $error("cal sample stuck"); // RQ15

    property p_cal_strobe;
        ##1 analog_ctl_q.osc_cal_strobe
            == $past(regs_q[`RAC_IX_TST3][7] && regs_q[`RAC_IX_TST3][6]);
    endproperty
    a_cal_strobe: assert property (p_cal_strobe) else $error("cal strobe wrong"); // RQ15

    property p_cal_result;
        !analog_ctl_q.osc_cal_sample |-> $stable(analog_ctl_q.osc_cal_result);
    endproperty
    a_cal_result: assert property (p_cal_result) else $error("cal result moved"); // RQ15

    // Registers move only on a decoded write; unmapped writes must leave them alone
    generate
        for (genvar h = 0; h < NUM_REGS; h++) begin : g_hold
            property p_reg_hold;
                @(posedge core_clk) disable iff (rst)
                !(wr_q.we && wr_sel == {1'b1, 3'(h)}) |=> $stable(regs_q[h]);
            endproperty
            a_reg_hold: assert property (p_reg_hold) else $error("register moved"); // RQ16
        end
    endgenerate

    property p_cov_write;
        wr_q.we && wr_sel[3];
    endproperty
    c_cov_write: cover property (p_cov_write);

    property p_cov_sleep;
        block_sleep_bits_policy == `RAC_POLICY_SLEEP ##1 analog_ctl_q.sleep != 8'h00;
    endproperty
    c_cov_sleep: cover property (p_cov_sleep);

    property p_cov_cal;
        analog_ctl_q.osc_cal_sample;
    endproperty
    c_cov_cal: cover property (p_cov_cal);

    property p_cov_loop;
        analog_ctl_q.loop_open;
    endproperty
    c_cov_loop: cover property (p_cov_loop);

    property p_cov_strobe;
        analog_ctl_q.osc_cal_strobe;
    endproperty
    c_cov_strobe: cover property (p_cov_strobe);
endmodule
`default_nettype wire

// ==== dv/rac_host_model.sv ====
// Host model driving the serial configuration port of the analog bank
`timescale 1ns/10ps
`default_nettype none
module rac_host_model (
    input  wire logic core_clk,
    input  wire logic pdo_q,
    output logic      pclk,
    output logic      pdi,
    output logic      psel_n
);
    logic [7:0] rd_q;

    initial begin
        pclk = 1'b0;
        pdi = 1'b0;
        psel_n = 1'b1;
        rd_q = 8'h00;
    end

    task automatic hold(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    // Four-cycle pclk phases leave margin over the two-cycle minimum and the
    // sampling delay of pdo_q; pclk stands low between frames
    task automatic frame(input logic [6:0] addr, input logic wr, input logic [7:0] dat,
                         input int nbits);
        logic [15:0] sh;
        sh = {addr, wr, dat};
        rd_q = 8'h00;
        psel_n = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            pclk = 1'b0;
            pdi = sh[15 - i];
            hold(4);
            if (i >= 8) rd_q = {rd_q[6:0], pdo_q};
            pclk = 1'b1;
            hold(4);
        end
        pclk = 1'b0;
        psel_n = 1'b1;
        // Released data line must not keep showing the last bit
        pdi = ~pdi;
        hold(2);
    endtask
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
// Self-checking bench for the radio analog control register bank
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic                 core_clk;
    logic                 rst;
    logic                 pclk;
    logic                 pdi;
    logic                 psel_n;
    logic                 pdo_q;
    logic [1:0]           policy;
    logic [3:0]           c_dac;
    logic [3:0]           c_pump;
    logic [4:0]           c_arr;
    logic [5:0]           c_cur;
    logic                 cmp;
    logic                 res;
    logic [7:0]           d;
    logic [7:0]           r [8];
    rac_pkg::rac_analog_t ana;
    int                   err_total = 0;
    int                   n_tests = 0;
    int                   cyc = 0;
    int                   seed;
    int                   n_samp = 0;

    rac_host_model u_host (.core_clk(core_clk), .pdo_q(pdo_q), .pclk(pclk), .pdi(pdi),
                           .psel_n(psel_n));

    rac_analog_regs u_dut (.core_clk(core_clk), .rst(rst), .pclk(pclk), .pdi(pdi),
        .psel_n(psel_n), .pdo_q(pdo_q), .block_sleep_bits_policy(policy), .cal_dac_value(c_dac),
        .cal_pump_current(c_pump), .cal_osc_array(c_arr), .cal_osc_current(c_cur),
        .osc_cal_compare(cmp), .analog_ctl_q(ana));

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // About 80 frames of 98 to 134 cycles each fit well inside this ceiling
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            stop_test();
        end
    end

    // The sample pulse stands one cycle, so it is counted here rather than compared
    always @(negedge core_clk) begin
        if (ana.osc_cal_sample === 1'b1) n_samp++;
    end

    function automatic rac_pkg::rac_analog_t exp_ana();
        rac_pkg::rac_analog_t e;
        e.high_array_power = r[0][7:4];
        e.low_array_power = r[0][3:0];
        e.rx_match = r[1][7:4];
        e.tx_match = r[1][3:0];
        e.phase_trim = r[2];
        e.gain_trim = r[3];
        e.sleep = (policy == 2'h2) ? r[4] : 8'h00;
        e.loop_open = r[6][7];
        e.cal_dac = r[6][7] ? r[5][7:4] : c_dac;
        e.pump_current = r[6][6] ? r[5][3:0] : c_pump;
        e.osc_array = r[6][5] ? r[6][4:0] : c_arr;
        e.osc_current = r[7][6] ? r[7][5:0] : c_cur;
        e.osc_cal_by_hand = r[7][7];
        e.osc_cal_strobe = r[7][7] & r[7][6];
        e.osc_cal_sample = 1'b0;
        e.osc_cal_result = res;
        return e;
    endfunction

    task automatic chk_ana();
        rac_pkg::rac_analog_t e;
        e = exp_ana();
        n_tests++;
        if (ana !== e) begin
            err_total++;
            $display("ERROR %0t analog outputs %h expected %h", $time, ana, e);
        end
    endtask

    task automatic chk_rd(input logic [7:0] exp);
        n_tests++;
        if (u_host.rd_q !== exp) begin
            err_total++;
            $display("ERROR %0t read %h expected %h", $time, u_host.rd_q, exp);
        end
    endtask

    task automatic chk_samp(input int exp);
        n_tests++;
        if (n_samp != exp) begin
            err_total++;
            $display("ERROR %0t cal samples %0d expected %0d", $time, n_samp, exp);
        end
    endtask

    task automatic wr(input int i, input logic [7:0] v);
        if (i == 7 && r[7][7] && r[7][6] && v[7] && !v[6]) res = cmp;
        u_host.frame(7'h1C + 7'(i), 1'b1, v, 16);
        r[i] = v;
        u_host.hold(4);
    endtask

    task automatic rd(input int i);
        u_host.frame(7'h1C + 7'(i), 1'b0, 8'h00, 16);
        chk_rd(r[i]);
    endtask

    task automatic rnd_cal();
        {c_dac, c_pump, c_arr, c_cur} = 19'($random(seed));
        policy = 2'($random(seed));
    endtask

    task automatic end_test(input string name);
        $display("test %s done, mismatches so far %0d", name, err_total);
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        seed = 23907;
        rst = 1'b1;
        policy = 2'h0;
        {c_dac, c_pump, c_arr, c_cur} = 19'h0;
        cmp = 1'b0;
        res = 1'b0;
        r = '{8'h0F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h4D, 8'h10, 8'h06};
        repeat (6) @(negedge core_clk);
        rst = 1'b0;
        u_host.hold(2);
        chk_ana();
        for (int i = 0; i < 8; i++) rd(i);
        end_test("reset");
        for (int k = 0; k < 24; k++) begin
            rnd_cal();
            d = 8'($random(seed));
            // Manual calibration bit stays clear so no sample is taken here
            if (k % 8 == 7) d[7] = 1'b0;
            wr(k % 8, d);
            chk_ana();
            rd(k % 8);
        end
        end_test("random");
        wr(0, 8'h50);
        wr(2, 8'h80);
        wr(3, 8'h7F);
        chk_ana();
        rd(2);
        rd(3);
        wr(4, 8'hA5);
        for (int p = 0; p < 4; p++) begin
            policy = 2'(p);
            u_host.hold(2);
            chk_ana();
        end
        end_test("corners");
        for (int m = 0; m < 8; m++) begin
            rnd_cal();
            wr(6, {3'(m), 5'h0B});
            chk_ana();
        end
        wr(7, 8'h6A);
        chk_ana();
        wr(7, 8'h2A);
        chk_ana();
        end_test("overrides");
        u_host.frame(7'h24, 1'b1, 8'hFF, 16);
        u_host.frame(7'h24, 1'b0, 8'h00, 16);
        chk_rd(8'h00);
        u_host.frame(7'h1B, 1'b0, 8'h00, 16);
        chk_rd(8'h00);
        u_host.frame(7'h1C, 1'b1, 8'h33, 12);
        u_host.hold(4);
        chk_ana();
        rd(0);
        end_test("refusals");
        wr(7, 8'hC0);
        cmp = 1'b1;
        wr(7, 8'h80);
        chk_ana();
        cmp = 1'b0;
        wr(7, 8'hC0);
        wr(7, 8'h80);
        chk_ana();
        cmp = 1'b1;
        wr(7, 8'h40);
        wr(7, 8'h00);
        chk_ana();
        chk_samp(2);
        end_test("manual_cal");
        stop_test();
    end
endmodule
`default_nettype wire
